// *** hdl/crc_accumulate_unit_consts.svh ***
// offsets, field positions, reset values and counts of the crc unit
`ifndef CRC_ACCUMULATE_UNIT_CONSTS_SVH
`define CRC_ACCUMULATE_UNIT_CONSTS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define CRC_OFS_CTRL 8'h00
`define CRC_OFS_ACC_IN 8'h04
`define CRC_OFS_DATA_SRC 8'h08
`define CRC_OFS_OP 8'h0C
`define CRC_OFS_STATUS 8'h10
`define CRC_OFS_RESULT 8'h14
`define CRC_OFS_FEATURE 8'h18

// ****************************************
// reset values
// ****************************************
`define CRC_RST_WORD 32'h0000_0000

// ****************************************
// status bit positions
// ****************************************
`define CRC_ST_BUSY 0
`define CRC_ST_DONE 1
`define CRC_ST_UNDEF 2
`define CRC_ST_NOP 3
`define CRC_ST_WROTE 4
`define CRC_ST_DEST_LSB 8

// ****************************************
// polynomials and encodings
// ****************************************
`define CRC_POLY_ETH 32'h04C1_1DB7
`define CRC_POLY_CAST 32'h1EDC_6F41
`define CRC_COND_ALWAYS 4'hE
`define CRC_SIZE_BYTE 2'h0
`define CRC_SIZE_HALF 2'h1
`define CRC_SIZE_WORD 2'h2
`define CRC_SIZE_DWORD 2'h3
`define CRC_PC_IDX 4'hF
`define CRC_POL_UNDEF 2'h0
`define CRC_POL_NOP 2'h1
`define CRC_POL_UNCOND 2'h2
`define CRC_POL_COND 2'h3
`define CRC_FEAT_CRC_PRESENT 4'h1

// ****************************************
// timing counts, in clock cycles
// ****************************************
`define CRC_BITS_BYTE 6'h08
`define CRC_BITS_HALF 6'h10
`define CRC_BITS_WORD 6'h20
`define CRC_BITS_SKIP 6'h01

`endif

// *** hdl/crc_accumulate_unit_pkg.sv ***
// types shared by the crc accumulate unit
package crc_accumulate_unit_pkg;

  // ****************************************
  // engine state and instruction outcome
  // ****************************************
  typedef enum logic {ST_IDLE, ST_RUN} state_t;
  typedef enum logic [1:0] {OUT_EXEC, OUT_NOP, OUT_UNDEF} outcome_t;

  // ****************************************
  // launched instruction word
  // ****************************************
  typedef struct packed {
    logic [9:0] rsvd;             // reads as zero
    logic [3:0] data_idx;         // data_source_reg index
    logic [3:0] acc_idx;          // accumulator_input_reg index
    logic [3:0] dest_idx;         // accumulator output index
    logic cond_pass;              // condition check result
    logic in_conditional_block;   // mixed-width, inside block
    logic fixed_enc;              // 1: 32-bit fixed-width encoding
    logic [3:0] cond;             // condition field
    logic castagnoli_crc_op;      // polynomial select
    logic [1:0] operand_size_field; // 00 byte, 01 half, 10 word
  } op_word_t;

  // ****************************************
  // control word
  // ****************************************
  typedef struct packed {
    logic [24:0] rsvd;            // reads as zero
    logic data_independent_timing_ctrl; // constant-time request
    logic [1:0] block_pol;        // outcome inside conditional block
    logic [1:0] cond_pol;         // outcome for non-always cond
    logic [1:0] size64_pol;       // outcome for size code 11
  } ctrl_t;

endpackage : crc_accumulate_unit_pkg

// *** hdl/crc_accumulate_unit.sv ***
// crc accumulate execution unit with apb register access
//
// Overview of operation
// (R1) operand of 8, 16 or 32 bits
// (R2) select ethernet or castagnoli polynomial
// (R3) bit-reverse inputs and the remainder
// (R4) pad, xor, divide modulo two
// (R5) only low size bits of data used
// (R6) read accumulator and data, write result
// (R7) no crc extension means undefined
// (R8) size code 11: undefined, nop or 32
// (R9) register 15 use gets undefined behaviour
// (R10) non-always condition follows chosen policy
// (R11) inside conditional block follows chosen policy
// (R12) execution time independent of data
// (R13) exception response independent of data
// (R14) feature field reports crc support
// (R15) write only when passed and defined
//
// The implementer's own choices: the APB slave port and the register offsets.
`include "crc_accumulate_unit_consts.svh"

module crc_accumulate_unit
  import crc_accumulate_unit_pkg::*;
#(
  parameter bit CRC_EXT = 1'b1 // crc extension built in
) (
  input wire logic pclk, // bus clock, 40 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // slave select
  input wire logic penable, // access phase
  input wire logic pwrite, // 1 write, 0 read
  input wire logic [7:0] paddr, // byte address
  input wire logic [31:0] pwdata, // write data
  output logic [31:0] prdata, // read data
  output logic pready, // transfer done
  output logic pslverr // unmapped address
);

  // ****************************************
  // helpers
  // ****************************************
  // mirror a 32-bit word end to end
  function automatic logic [31:0] bit_order_reverse(
    input logic [31:0] w
  );
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 0; i < 32; i++) begin
      r[i] = w[31 - i];
    end
    return r;
  endfunction : bit_order_reverse

  // address hits a mapped register
  function automatic logic addr_mapped(input logic [7:0] a);
    return a == `CRC_OFS_CTRL || a == `CRC_OFS_ACC_IN ||
      a == `CRC_OFS_DATA_SRC || a == `CRC_OFS_OP ||
      a == `CRC_OFS_STATUS || a == `CRC_OFS_RESULT ||
      a == `CRC_OFS_FEATURE;
  endfunction : addr_mapped

  // ****************************************
  // declarations
  // ****************************************
  logic [31:0] prdata_q, prdata_d; // registered read data
  logic pready_q, pready_d; // registered ready
  logic pslverr_q, pslverr_d; // registered error
  ctrl_t ctrl_q, ctrl_d; // policies and timing control
  logic [31:0] acc_in_q, acc_in_d; // accumulator_input_reg value
  logic [31:0] data_src_q, data_src_d; // data_source_reg value
  op_word_t op_q, op_d; // last launched instruction
  logic [31:0] result_q, result_d; // accumulator output value
  logic [31:0] crc_q, crc_d; // running remainder
  logic [31:0] shift_q, shift_d; // reversed data, msb first
  logic [5:0] cnt_q, cnt_d; // cycles left in run
  state_t state_q, state_d; // engine state
  outcome_t outcome_q, outcome_d; // decided outcome
  logic done_q, done_d; // sticky completion
  logic wrote_q, wrote_d; // destination written
  logic [31:0] poly_q, poly_d; // selected polynomial
  logic wr_en; // write takes effect
  logic start; // launch accepted
  op_word_t op_w; // incoming instruction
  outcome_t outcome_w; // decoded outcome
  logic [5:0] nbits_w; // effective operand bits
  logic [31:0] mask_w; // low size bits of data
  logic [31:0] status_w; // status word
  logic [31:0] feature_w; // feature word
  logic fb_w; // division feedback bit

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign wr_en = psel && penable && pready_q && pwrite;
  assign op_w = op_word_t'(pwdata);
  // a new op is taken only while the engine is idle
  assign start = wr_en && paddr == `CRC_OFS_OP && state_q == ST_IDLE;

  // ****************************************
  // read-only words
  // ****************************************
  always_comb begin
    status_w = 32'h0000_0000;
    status_w[`CRC_ST_BUSY] = state_q == ST_RUN;
    status_w[`CRC_ST_DONE] = done_q;
    status_w[`CRC_ST_UNDEF] = outcome_q == OUT_UNDEF;
    status_w[`CRC_ST_NOP] = outcome_q == OUT_NOP;
    status_w[`CRC_ST_WROTE] = wrote_q;
    status_w[`CRC_ST_DEST_LSB +: 4] = op_q.dest_idx;
    feature_w = 32'h0000_0000;
    if (CRC_EXT) begin
      feature_w[3:0] = `CRC_FEAT_CRC_PRESENT; // R14
    end
  end

  // ****************************************
  // decode of the launched instruction
  // ****************************************
  always_comb begin
    outcome_w = OUT_EXEC;
    nbits_w = `CRC_BITS_BYTE;
    // size code picks the operand width
    unique case (op_w.operand_size_field)
      `CRC_SIZE_BYTE: nbits_w = `CRC_BITS_BYTE; // R1
      `CRC_SIZE_HALF: nbits_w = `CRC_BITS_HALF; // R1
      `CRC_SIZE_WORD: nbits_w = `CRC_BITS_WORD; // R1
      `CRC_SIZE_DWORD: begin
        nbits_w = `CRC_BITS_WORD; // R8
        if (ctrl_q.size64_pol == `CRC_POL_UNDEF) begin
          outcome_w = OUT_UNDEF; // R8
        end else if (ctrl_q.size64_pol == `CRC_POL_NOP) begin
          outcome_w = OUT_NOP; // R8
        end
      end
    endcase
    // fixed-width encoding with a condition other than always
    if (op_w.fixed_enc && op_w.cond != `CRC_COND_ALWAYS &&
        outcome_w == OUT_EXEC) begin
      unique case (ctrl_q.cond_pol)
        `CRC_POL_UNDEF: outcome_w = OUT_UNDEF; // R10
        `CRC_POL_NOP: outcome_w = OUT_NOP; // R10
        `CRC_POL_UNCOND: outcome_w = OUT_EXEC; // R10
        `CRC_POL_COND: begin
          outcome_w = op_w.cond_pass ? OUT_EXEC : OUT_NOP; // R10
        end
      endcase
    end
    // mixed-width encoding placed inside a conditional block
    if (!op_w.fixed_enc && op_w.in_conditional_block &&
        outcome_w == OUT_EXEC) begin
      unique case (ctrl_q.block_pol)
        `CRC_POL_UNDEF: outcome_w = OUT_UNDEF; // R11
        `CRC_POL_NOP: outcome_w = OUT_NOP; // R11
        `CRC_POL_UNCOND: outcome_w = OUT_EXEC; // R11
        `CRC_POL_COND: begin
          outcome_w = op_w.cond_pass ? OUT_EXEC : OUT_NOP; // R11
        end
      endcase
    end
    // program counter as any operand is always undefined
    if (op_w.dest_idx == `CRC_PC_IDX || op_w.acc_idx == `CRC_PC_IDX ||
        op_w.data_idx == `CRC_PC_IDX) begin
      outcome_w = OUT_UNDEF; // R9
    end
    // without the extension nothing else matters
    if (!CRC_EXT) begin
      outcome_w = OUT_UNDEF; // R7
    end
  end

  // mask keeping only the low size bits of the data
  always_comb begin
    mask_w = 32'hFFFF_FFFF;
    if (nbits_w == `CRC_BITS_BYTE) begin
      mask_w = 32'h0000_00FF; // R5
    end else if (nbits_w == `CRC_BITS_HALF) begin
      mask_w = 32'h0000_FFFF; // R5
    end
  end

  // ****************************************
  // apb slave and software registers
  // ****************************************
  // ready one cycle after setup, so every access is two cycles
  always_comb begin
    pready_d = psel && !penable;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    ctrl_d = ctrl_q;
    acc_in_d = acc_in_q;
    data_src_d = data_src_q;
    // read data and error are settled at the setup edge
    if (psel && !penable) begin
      pslverr_d = !addr_mapped(paddr);
      prdata_d = 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          `CRC_OFS_CTRL: prdata_d = 32'(ctrl_q);
          `CRC_OFS_ACC_IN: prdata_d = acc_in_q;
          `CRC_OFS_DATA_SRC: prdata_d = data_src_q;
          `CRC_OFS_OP: prdata_d = 32'(op_q);
          `CRC_OFS_STATUS: prdata_d = status_w;
          `CRC_OFS_RESULT: prdata_d = result_q;
          `CRC_OFS_FEATURE: prdata_d = feature_w; // R14
          default: prdata_d = 32'h0000_0000;
        endcase
      end
    end
    // writes land at the access edge
    if (wr_en) begin
      unique case (paddr)
        `CRC_OFS_CTRL: begin
          ctrl_d = ctrl_t'(pwdata);
          ctrl_d.rsvd = 25'h000_0000;
        end
        `CRC_OFS_ACC_IN: acc_in_d = pwdata; // R6
        `CRC_OFS_DATA_SRC: data_src_d = pwdata; // R6
        default: ;
      endcase
    end
  end

  // register the bus group
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= `CRC_RST_WORD;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      ctrl_q <= ctrl_t'(`CRC_RST_WORD);
      acc_in_q <= `CRC_RST_WORD;
      data_src_q <= `CRC_RST_WORD;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      ctrl_q <= ctrl_d;
      acc_in_q <= acc_in_d;
      data_src_q <= data_src_d;
    end
  end

  // ****************************************
  // crc engine
  // ****************************************
  // one bit per cycle, msb first; cycle count set by size, or one cycle for a skipped op
  assign fb_w = crc_q[31] ^ shift_q[31];

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    crc_d = crc_q;
    shift_d = shift_q;
    poly_d = poly_q;
    op_d = op_q;
    outcome_d = outcome_q;
    done_d = done_q;
    wrote_d = wrote_q;
    result_d = result_q;
    unique case (state_q)
      ST_IDLE: begin
        if (start) begin
          state_d = ST_RUN;
          op_d = op_w;
          op_d.rsvd = 10'h000;
          outcome_d = outcome_w;
          done_d = 1'b0;
          wrote_d = 1'b0;
          // fixed latency per size and outcome, never per data value
          cnt_d = outcome_w == OUT_EXEC ? nbits_w : `CRC_BITS_SKIP; // R12
          crc_d = bit_order_reverse(acc_in_q); // R3
          shift_d = bit_order_reverse(data_src_q & mask_w); // R3 R5
          poly_d = op_w.castagnoli_crc_op ? `CRC_POLY_CAST
                                          : `CRC_POLY_ETH; // R2
        end
      end
      ST_RUN: begin
        // long division: shift out, subtract poly on a one
        if (outcome_q == OUT_EXEC) begin
          crc_d = {crc_q[30:0], 1'b0} ^ (fb_w ? poly_q : 32'h0); // R4
          shift_d = {shift_q[30:0], 1'b0}; // R4
        end
        cnt_d = cnt_q - 6'h01;
        // nothing cuts a run short, so exceptions see fixed timing
        if (cnt_q == `CRC_BITS_SKIP) begin
          state_d = ST_IDLE; // R13
          done_d = 1'b1;
          // result_q is kept on a skipped op; only a passed op writes
          if (outcome_q == OUT_EXEC) begin
            result_d = bit_order_reverse(crc_d); // R3 R15
            wrote_d = 1'b1; // R15
          end
        end
      end
    endcase
  end

  // register the engine group
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      cnt_q <= 6'h00;
      crc_q <= `CRC_RST_WORD;
      shift_q <= `CRC_RST_WORD;
      poly_q <= `CRC_RST_WORD;
      op_q <= op_word_t'(`CRC_RST_WORD);
      outcome_q <= OUT_EXEC;
      done_q <= 1'b0;
      wrote_q <= 1'b0;
      result_q <= `CRC_RST_WORD;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      crc_q <= crc_d;
      shift_q <= shift_d;
      poly_q <= poly_d;
      op_q <= op_d;
      outcome_q <= outcome_d;
      done_q <= done_d;
      wrote_q <= wrote_d;
      result_q <= result_d;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_wait8;
    !done_q [*8];
  endsequence
  sequence s_finish;
    done_q && state_q == ST_IDLE;
  endsequence
  a_ready_after_setup:
    assert property (psel && !penable |=> pready)
    else $error("ready missing after setup");
  a_byte_latency: // R1
    assert property (start && outcome_w == OUT_EXEC &&
      op_w.operand_size_field == `CRC_SIZE_BYTE |=> s_wait8 ##1 s_finish)
    else $error("byte op not done in eight cycles");
  a_word_latency: // R12
    assert property (start && outcome_w == OUT_EXEC &&
      nbits_w == `CRC_BITS_WORD |-> ##33 $rose(done_q))
    else $error("word op latency wrong");
  a_run_uncut: // R13
    assert property (state_q == ST_RUN && cnt_q > `CRC_BITS_SKIP
      |=> state_q == ST_RUN)
    else $error("run ended early");
  a_ext_undef: // R7
    assert property (start && !CRC_EXT |=> ##1 s_finish and
      outcome_q == OUT_UNDEF)
    else $error("missing extension not undefined");
  a_pc_undef: // R9
    assert property (start && op_w.acc_idx == `CRC_PC_IDX
      |=> ##1 outcome_q == OUT_UNDEF && !wrote_q)
    else $error("pc operand not undefined");
  a_undef_keeps: // R15
    assert property ($rose(done_q) && outcome_q != OUT_EXEC
      |-> $stable(result_q) && !wrote_q)
    else $error("result written by skipped op");
  a_result_hold: // R6
    assert property (state_q == ST_RUN && cnt_q > `CRC_BITS_SKIP
      |=> $stable(result_q))
    else $error("result changed mid run");

endmodule : crc_accumulate_unit

// *** sim/crc_apb_master.sv ***
// apb master model standing in for the pipeline at the register port
module crc_apb_master (
  input wire logic pclk, // bus clock
  output logic psel, // slave select
  output logic penable, // access phase
  output logic pwrite, // 1 write, 0 read
  output logic [7:0] paddr, // byte address
  output logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // transfer done
  input wire logic pslverr // error response
);
  timeunit 1ns;
  timeprecision 1ps;

  logic hang; // set when a wait for pready runs out

  // ****************************************
  // idle bus at time zero
  // ****************************************
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    hang = 1'b0;
  end

  // ****************************************
  // one transfer: setup, access until pready
  // ****************************************
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) hang = 1'b1;
    q = prdata; // taken at the pready edge
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a; // released lines do not keep the old value
    pwdata <= ~d;
  endtask : xfer
endmodule : crc_apb_master

// *** sim/test_crc_accumulate_unit.sv ***
// self-checking bench of the crc accumulate unit
`include "crc_accumulate_unit_consts.svh"
module test_crc_accumulate_unit
  import crc_accumulate_unit_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, dup;
  logic pready_b, pslverr_b; // unit built without the extension
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, prdata_b, rd_b, acc, dat, q;
  op_word_t op, base;
  ctrl_t ctrl;
  outcome_t k;
  int n_fail = 0;
  int total_checks = 0;
  int pc[3] = '{0, 0, 0}; // poll counts seen per operand size

  crc_apb_master i_crc_apb_master (.pclk(pclk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  crc_accumulate_unit #(.CRC_EXT(1'b1)) i_crc_accumulate_unit (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  crc_accumulate_unit #(.CRC_EXT(1'b0)) i_crc_accumulate_unit_noext (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_b),
    .pready(pready_b), .pslverr(pslverr_b));

  // clock at 40 MHz
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // read data of the second unit, taken at its pready edge
  always @(posedge pclk) begin
    if (psel && penable && pready_b) rd_b <= prdata_b;
  end

  // ****************************************
  // checking and closing
  // ****************************************
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task summarize;
    if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  task xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_crc_apb_master.xfer(w, a, d, q, err);
    if (i_crc_apb_master.hang) begin
      n_fail++;
      summarize();
    end
  endtask : xf

  // reflected crc, one data bit per step, no preset or final inversion
  function automatic logic [31:0] ref_crc(logic [31:0] a, logic [31:0] v,
                                          int nb, logic c);
    logic [31:0] p;
    logic b;
    p = c ? `CRC_POLY_CAST : `CRC_POLY_ETH;
    p = {<<{p}};
    for (int i = 0; i < nb; i++) begin
      b = a[0] ^ v[i];
      a = a >> 1;
      if (b) a = a ^ p;
    end
    return a;
  endfunction : ref_crc

  function automatic logic [31:0] exp_status(outcome_t o);
    if (o == OUT_EXEC) return {20'h0_0000, op.dest_idx, 8'h12};
    if (o == OUT_NOP) return 32'h0000_000A;
    return 32'h0000_0006;
  endfunction : exp_status

  // launch one operation, poll until done, compare outcome
  task run(input outcome_t o, input int nb);
    int n;
    xf(1'b1, `CRC_OFS_ACC_IN, acc);
    xf(1'b1, `CRC_OFS_DATA_SRC, dat);
    xf(1'b1, `CRC_OFS_OP, op);
    if (dup) xf(1'b1, `CRC_OFS_OP, op ^ 32'h0000_0C00); // lands while busy
    n = 0;
    do begin
      xf(1'b0, `CRC_OFS_STATUS, 32'h0000_0000);
      n++;
      if (n == 1 && o == OUT_EXEC) check({30'h0, q[1:0]}, 32'h1);
    end while (q[1] !== 1'b1 && n < 40);
    if (n >= 40) begin
      n_fail++;
      summarize();
    end
    check(q & (o == OUT_EXEC ? 32'h0F1F : 32'h1F), exp_status(o));
    #1;
    check(rd_b & 32'h1F, 32'h0000_0006);
    if (o == OUT_EXEC) begin
      xf(1'b0, `CRC_OFS_RESULT, 32'h0000_0000);
      check(q, ref_crc(acc, dat, nb, op.castagnoli_crc_op));
      if (pc[nb / 16] == 0 && !dup) pc[nb / 16] = n;
      else if (!dup) check(n, pc[nb / 16]);
    end
  endtask : run

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    presetn = 1'b0;
    dup = 1'b0;
    void'($urandom(28));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, read-only and unmapped places
    xf(1'b0, `CRC_OFS_CTRL, 32'h0);
    check(q, `CRC_RST_WORD);
    xf(1'b1, `CRC_OFS_RESULT, 32'hFFFF_FFFF);
    xf(1'b0, `CRC_OFS_RESULT, 32'h0);
    check(q, `CRC_RST_WORD);
    xf(1'b0, `CRC_OFS_FEATURE, 32'h0);
    check(q, {28'h0, `CRC_FEAT_CRC_PRESENT});
    #1;
    check(rd_b, 32'h0000_0000);
    xf(1'b0, 8'h1C, 32'h0);
    check(q, 32'h0000_0000);
    check({31'h0, err}, 32'h0000_0001);
    ctrl = '0;
    ctrl.data_independent_timing_ctrl = 1'b1;
    ctrl.block_pol = 2'h2;
    xf(1'b1, `CRC_OFS_CTRL, ctrl);
    xf(1'b0, `CRC_OFS_CTRL, 32'h0);
    check(q, ctrl);
    base = '0;
    base.operand_size_field = `CRC_SIZE_WORD;
    base.cond = `CRC_COND_ALWAYS;
    base.fixed_enc = 1'b1;
    base.cond_pass = 1'b1;
    base.dest_idx = 4'h3;
    // random operations of every size and both polynomials
    for (int i = 0; i < 40; i++) begin
      acc = (i == 0) ? 32'hFFFF_FFFF : $urandom;
      dat = (i == 0) ? 32'h0000_0000 : $urandom;
      op = base;
      op.operand_size_field = 2'(i % 3);
      op.castagnoli_crc_op = 1'(i / 3);
      op.fixed_enc = 1'($urandom);
      op.dest_idx = 4'($urandom_range(14, 0));
      op.acc_idx = 4'($urandom_range(14, 0));
      op.data_idx = 4'($urandom_range(14, 0));
      run(OUT_EXEC, 8 << op.operand_size_field);
    end
    // every policy code of the three unpredictable cases
    for (int s = 0; s < 3; s++) begin
      for (int p = 0; p < 4; p++) begin
        ctrl = '0;
        op = base;
        case (s)
          0: begin
            ctrl.size64_pol = 2'(p);
            op.operand_size_field = `CRC_SIZE_DWORD;
          end
          1: begin
            ctrl.cond_pol = 2'(p);
            op.cond = 4'h0;
            op.cond_pass = 1'b1; // conditional policy must then execute
          end
          default: begin
            ctrl.block_pol = 2'(p);
            op.fixed_enc = 1'b0;
            op.in_conditional_block = 1'b1;
            op.cond_pass = 1'b0;
          end
        endcase
        xf(1'b1, `CRC_OFS_CTRL, ctrl);
        k = (p == 0) ? OUT_UNDEF : (p == 1 || (p == 3 && !op.cond_pass)) ?
            OUT_NOP : OUT_EXEC;
        run(k, 32);
      end
    end
    // register 15 in each index field
    for (int j = 0; j < 3; j++) begin
      op = base;
      if (j == 0) op.dest_idx = `CRC_PC_IDX;
      if (j == 1) op.acc_idx = `CRC_PC_IDX;
      if (j == 2) op.data_idx = `CRC_PC_IDX;
      run(OUT_UNDEF, 32);
    end
    // second launch while busy is dropped
    op = base;
    dup = 1'b1;
    run(OUT_EXEC, 32);
    summarize();
  end
endmodule : test_crc_accumulate_unit
